// file: verilog/smcg_top.sv
// Purpose: Sleep controller gating core, flash and io clock enables.
// Assumes: Wake and enable inputs are synchronous to clk.
// Notes: Gating is expressed as registered clock enables, not gated clocks.
`timescale 1ns/1ps
module smcg_top (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// Core request
	input  wire logic        sleep_exec,
	input  wire logic        sleep_enable,
	input  wire logic [2:0]  sleep_mode_select,
	input  wire logic [1:0]  clock_source_fuses,
	// Peripheral state
	input  wire logic        adc_enable,
	input  wire logic        comparator_disable,
	// Wake sources
	input  wire logic        any_irq,
	input  wire logic        adc_done_irq,
	input  wire logic        ext_reset,
	input  wire logic        wdt_reset,
	input  wire logic        bod_reset,
	input  wire logic        lcd_irq,
	input  wire logic        serial_start_irq,
	input  wire logic        timer2_irq,
	input  wire logic        store_ready_irq,
	input  wire logic        level_irq_zero,
	input  wire logic        pin_change_irq,
	// Clock enables and status
	output logic             core_clk_en,
	output logic             flash_clk_en,
	output logic             io_clk_en,
	output logic             async_clk_en,
	output logic             osc_en,
	output logic             comparator_power,
	output logic             adc_start,
	output logic             asleep,
	output logic [1:0]       state_out
);
	import smcg_pkg::*;

	smcg_state_e state_q;
	logic [2:0]  mode_q;
	logic        wake_now;
	logic        dly_start;
	logic        dly_done;
	logic [15:0] dly_cycles;
	logic        pd_wake;
	logic        noise_wake;
	logic        enter;

	// Core clock is the undivided source; the enable only stops it.
	assign enter = sleep_exec && sleep_enable && (state_q == SMCG_RUN)
	    && (sleep_mode_select <= SMCG_MODE_PDOWN);
	assign pd_wake = ext_reset | wdt_reset | bod_reset | serial_start_irq
	    | level_irq_zero | pin_change_irq;
	assign noise_wake = pd_wake | adc_done_irq | lcd_irq | timer2_irq
	    | store_ready_irq;

	always_comb begin
		wake_now = 1'b0;
		case (mode_q)
			SMCG_MODE_IDLE:  wake_now = any_irq | pd_wake;
			SMCG_MODE_NOISE: wake_now = noise_wake;
			SMCG_MODE_PDOWN: wake_now = pd_wake;
			default:         wake_now = 1'b1;
		endcase
	end

	always_comb begin
		dly_cycles = SMCG_DLY_CYC0;
		case (clock_source_fuses)
			2'h0:    dly_cycles = SMCG_DLY_CYC0;
			2'h1:    dly_cycles = SMCG_DLY_CYC1;
			2'h2:    dly_cycles = SMCG_DLY_CYC2;
			default: dly_cycles = SMCG_DLY_CYC3;
		endcase
	end

	assign dly_start = (state_q == SMCG_SLEEP) && wake_now && (mode_q == SMCG_MODE_PDOWN);

	smcg_delay u_delay (
		.clk    (clk),
		.rst    (rst),
		.start  (dly_start),
		.cycles (dly_cycles),
		.done   (dly_done)
	);

	always_ff @(posedge clk) begin
		if (rst) begin
			state_q <= SMCG_RUN;
			mode_q  <= SMCG_MODE_IDLE;
		end else begin
			case (state_q)
				SMCG_RUN: begin
					if (enter) begin
						state_q <= SMCG_SLEEP;
						mode_q  <= sleep_mode_select;
					end
				end
				SMCG_SLEEP: begin
					if (wake_now) begin
						// Oscillator must settle before the core resumes.
						state_q <= (mode_q == SMCG_MODE_PDOWN) ? SMCG_RESTART : SMCG_RUN;
					end
				end
				SMCG_RESTART: begin
					if (dly_done) begin
						state_q <= SMCG_RUN;
					end
				end
				default: state_q <= SMCG_RUN;
			endcase
		end
	end

	// Enables follow the next state so gating starts with the sleep entry.
	always_ff @(posedge clk) begin
		if (rst) begin
			core_clk_en  <= 1'b1;
			flash_clk_en <= 1'b1;
			io_clk_en    <= 1'b1;
			async_clk_en <= 1'b1;
			osc_en       <= 1'b1;
			asleep       <= 1'b0;
		end else if (enter) begin
			core_clk_en  <= 1'b0;
			flash_clk_en <= 1'b0;
			io_clk_en    <= (sleep_mode_select == SMCG_MODE_IDLE);
			async_clk_en <= (sleep_mode_select != SMCG_MODE_PDOWN);
			osc_en       <= (sleep_mode_select != SMCG_MODE_PDOWN);
			asleep       <= 1'b1;
		end else if (state_q == SMCG_SLEEP && wake_now) begin
			osc_en       <= 1'b1;
			if (mode_q != SMCG_MODE_PDOWN) begin
				core_clk_en  <= 1'b1;
				flash_clk_en <= 1'b1;
				io_clk_en    <= 1'b1;
				async_clk_en <= 1'b1;
				asleep       <= 1'b0;
			end
		end else if (state_q == SMCG_RESTART && dly_done) begin
			core_clk_en  <= 1'b1;
			flash_clk_en <= 1'b1;
			io_clk_en    <= 1'b1;
			async_clk_en <= 1'b1;
			asleep       <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			adc_start <= 1'b0;
		end else begin
			adc_start <= enter && adc_enable
			    && (sleep_mode_select != SMCG_MODE_PDOWN);
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			comparator_power <= 1'b1;
			state_out        <= 2'h0;
		end else begin
			comparator_power <= ~comparator_disable;
			state_out        <= 2'(state_q);
		end
	end

	sequence pd_entry_s;
		enter && sleep_mode_select == SMCG_MODE_PDOWN;
	endsequence

	sequence pd_wake_s;
		state_q == SMCG_SLEEP && mode_q == SMCG_MODE_PDOWN && wake_now;
	endsequence

	idle_gating_a: assert property (@(posedge clk) disable iff (rst)
		enter && sleep_mode_select == SMCG_MODE_IDLE |=>
		!core_clk_en && !flash_clk_en && io_clk_en && osc_en)
		else $error("idle gating wrong");
	noise_gating_a: assert property (@(posedge clk) disable iff (rst)
		enter && sleep_mode_select == SMCG_MODE_NOISE |=>
		!core_clk_en && !io_clk_en && async_clk_en && osc_en)
		else $error("noise gating wrong");
	pdown_gating_a: assert property (@(posedge clk) disable iff (rst)
		pd_entry_s |=> !osc_en && !async_clk_en && !io_clk_en && !core_clk_en)
		else $error("power-down gating wrong");
	reserved_mode_a: assert property (@(posedge clk) disable iff (rst)
		state_q == SMCG_RUN && sleep_mode_select > SMCG_MODE_PDOWN |=> state_q == SMCG_RUN)
		else $error("reserved mode slept");
	adc_start_a: assert property (@(posedge clk) disable iff (rst)
		enter && adc_enable && sleep_mode_select != SMCG_MODE_PDOWN |=> adc_start)
		else $error("conversion not started");
	noise_wake_a: assert property (@(posedge clk) disable iff (rst)
		state_q == SMCG_SLEEP && mode_q == SMCG_MODE_NOISE && !noise_wake |=>
		state_q == SMCG_SLEEP)
		else $error("noise mode woke wrongly");
	pd_restart_a: assert property (@(posedge clk) disable iff (rst)
		pd_wake_s |=> !core_clk_en [*2])
		else $error("power-down woke without delay");
	pd_only_a: assert property (@(posedge clk) disable iff (rst)
		state_q == SMCG_SLEEP && mode_q == SMCG_MODE_PDOWN && !pd_wake |=>
		state_q == SMCG_SLEEP)
		else $error("power-down woke wrongly");
	idle_wake_a: assert property (@(posedge clk) disable iff (rst)
		state_q == SMCG_SLEEP && mode_q == SMCG_MODE_IDLE && any_irq |=> core_clk_en)
		else $error("idle did not wake");
	comp_power_a: assert property (@(posedge clk) disable iff (rst)
		comparator_disable |=> !comparator_power)
		else $error("comparator still powered");

	// The core must stay stopped for the whole restart count, not just its first cycles.
	restart_hold_a: assert property (@(posedge clk) disable iff (rst)
		state_q == SMCG_RESTART && !dly_done |=> !core_clk_en && !asleep == 1'b0)
		else $error("core resumed during restart");
	restart_osc_a: assert property (@(posedge clk) disable iff (rst)
		state_q == SMCG_RESTART |-> osc_en)
		else $error("oscillator off during restart");
	pd_no_adc_a: assert property (@(posedge clk) disable iff (rst)
		pd_entry_s |=> !adc_start)
		else $error("conversion started in power-down");
	idle_keep_a: assert property (@(posedge clk) disable iff (rst)
		state_q == SMCG_SLEEP && mode_q == SMCG_MODE_IDLE |-> io_clk_en && async_clk_en && osc_en)
		else $error("idle stopped a peripheral clock");
	reserved_quiet_a: assert property (@(posedge clk) disable iff (rst)
		state_q == SMCG_RUN && sleep_exec && sleep_mode_select > SMCG_MODE_PDOWN |=>
		core_clk_en && io_clk_en && osc_en && !adc_start)
		else $error("reserved mode touched a clock");
endmodule

// file: verilog/smcg_pkg.sv
// Purpose: Constants for the sleep mode clock gating block.
// Assumes: One 40 MHz clock, synchronous active-high reset.
// Notes: Restart delays are counted in cycles of the block clock.
// What this block does
// - Core clock is source clock, never divided.
// - Mode 000 Idle gates core and flash.
// - Idle keeps peripherals; any interrupt wakes.
// - Comparator disable bit powers comparator down.
// - Idle/noise entry starts conversion if enabled.
// - Mode 001 gates io, core, flash.
// - Noise mode keeps listed units if enabled.
// - Noise mode ends only on listed events.
// - Mode 010 stops oscillator, all clocks.
// - Power-down wakes only on listed events.
// - Power-down wake waits fuse-selected restart delay.
package smcg_pkg;
	localparam logic [2:0] SMCG_MODE_IDLE  = 3'h0;
	localparam logic [2:0] SMCG_MODE_NOISE = 3'h1;
	localparam logic [2:0] SMCG_MODE_PDOWN = 3'h2;
	localparam int         SMCG_CLK_MHZ    = 40;
	localparam int         SMCG_DLY_US0    = 4;
	localparam int         SMCG_DLY_US1    = 65;
	// Restart delay counts in cycles, one per fuse setting, rounded up.
	localparam logic [15:0] SMCG_DLY_CYC0  = 16'(SMCG_DLY_US0 * SMCG_CLK_MHZ);
	localparam logic [15:0] SMCG_DLY_CYC1  = 16'(SMCG_DLY_US1 * SMCG_CLK_MHZ);
	localparam logic [15:0] SMCG_DLY_CYC2  = 16'h0006;
	localparam logic [15:0] SMCG_DLY_CYC3  = 16'h0400;
	localparam int          SMCG_NWAKE     = 10;
	typedef enum logic [1:0] {SMCG_RUN, SMCG_SLEEP, SMCG_RESTART} smcg_state_e;
endpackage

// file: verilog/smcg_delay.sv
// Purpose: Restart delay counter after Power-down wake.
// Assumes: start is a one-cycle pulse.
// Notes: done pulses once when the loaded count expires.
`timescale 1ns/1ps
module smcg_delay (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// Control
	input  wire logic        start,
	input  wire logic [15:0] cycles,
	output logic             done
);
	import smcg_pkg::*;
	logic [15:0] cnt_q;
	logic        busy_q;

	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_q  <= 16'h0;
			busy_q <= 1'b0;
			done   <= 1'b0;
		end else begin
			done <= 1'b0;
			if (start) begin
				cnt_q  <= cycles;
				busy_q <= 1'b1;
			end else if (busy_q) begin
				if (cnt_q <= 16'h1) begin
					busy_q <= 1'b0;
					done   <= 1'b1;
				end else begin
					cnt_q <= cnt_q - 16'h1;
				end
			end
		end
	end
endmodule

// file: tb/smcg_top_bench.sv
// Purpose: Self-checking bench for the sleep mode clock gating block.
// Assumes: Inputs change on the falling edge; fuse setting 2 keeps restarts short.
// Notes: Clock enables are packed as core, flash, io and oscillator for comparison.
`timescale 1ns/1ps
module smcg_top_bench;
	import smcg_pkg::*;

	logic       clk, rst, sleep_exec, sleep_enable, adc_enable, comparator_disable;
	logic [2:0] sleep_mode_select;
	logic [1:0] clock_source_fuses, state_out;
	logic       any_irq, adc_done_irq, ext_reset, wdt_reset, bod_reset, lcd_irq;
	logic       serial_start_irq, timer2_irq, store_ready_irq, level_irq_zero, pin_change_irq;
	logic       core_clk_en, flash_clk_en, io_clk_en, async_clk_en, osc_en;
	logic       comparator_power, adc_start, asleep;
	int         err_total, n_checks;

	smcg_top DUT (.clk(clk), .rst(rst), .sleep_exec(sleep_exec), .sleep_enable(sleep_enable),
		.sleep_mode_select(sleep_mode_select), .clock_source_fuses(clock_source_fuses),
		.adc_enable(adc_enable), .comparator_disable(comparator_disable), .any_irq(any_irq),
		.adc_done_irq(adc_done_irq), .ext_reset(ext_reset), .wdt_reset(wdt_reset),
		.bod_reset(bod_reset), .lcd_irq(lcd_irq), .serial_start_irq(serial_start_irq),
		.timer2_irq(timer2_irq), .store_ready_irq(store_ready_irq),
		.level_irq_zero(level_irq_zero), .pin_change_irq(pin_change_irq),
		.core_clk_en(core_clk_en), .flash_clk_en(flash_clk_en), .io_clk_en(io_clk_en),
		.async_clk_en(async_clk_en), .osc_en(osc_en), .comparator_power(comparator_power),
		.adc_start(adc_start), .asleep(asleep), .state_out(state_out));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task automatic report_and_stop();
		if (err_total == 0 && n_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [3:0] exp, input logic [3:0] got);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask

	function automatic logic [3:0] ens();
		return {core_clk_en, flash_clk_en, io_clk_en, osc_en};
	endfunction

	// Issues one sleep instruction and counts conversion-start pulses that follow.
	task automatic enter(input logic [2:0] mode, input logic adc, output int starts);
		starts = 0;
		@(negedge clk);
		sleep_mode_select = mode;
		adc_enable = adc;
		sleep_exec = 1'b1;
		@(negedge clk);
		sleep_exec = 1'b0;
		repeat (3) begin
			if (adc_start === 1'b1) starts++;
			@(negedge clk);
		end
	endtask

	task automatic idle_case();
		int s;
		enter(SMCG_MODE_IDLE, 1'b1, s);
		chk("idle_adc_start", 4'h1, 4'(s));
		chk("idle_enables", 4'h3, ens());
		chk("idle_async", 4'h1, {3'h0, async_clk_en});
		chk("idle_asleep", 4'h1, {3'h0, asleep});
		any_irq = 1'b1;
		@(negedge clk);
		any_irq = 1'b0;
		repeat (2) @(negedge clk);
		chk("idle_wake", 4'hf, ens());
		enter(SMCG_MODE_IDLE, 1'b0, s);
		chk("idle_no_adc", 4'h0, 4'(s));
		timer2_irq = 1'b1;
		any_irq = 1'b1;
		@(negedge clk);
		timer2_irq = 1'b0;
		any_irq = 1'b0;
		repeat (2) @(negedge clk);
		chk("idle_irq_wake", 4'hf, ens());
	endtask

	task automatic noise_case();
		int s;
		enter(SMCG_MODE_NOISE, 1'b1, s);
		chk("noise_adc_start", 4'h1, 4'(s));
		chk("noise_enables", 4'h1, ens());
		chk("noise_async", 4'h1, {3'h0, async_clk_en});
		chk("noise_state", 4'h1, {2'h0, state_out});
		any_irq = 1'b1;
		repeat (3) @(negedge clk);
		any_irq = 1'b0;
		chk("noise_stays", 4'h1, {3'h0, asleep});
		lcd_irq = 1'b1;
		@(negedge clk);
		lcd_irq = 1'b0;
		repeat (2) @(negedge clk);
		chk("noise_wake", 4'hf, ens());
	endtask

	task automatic pdown_case();
		int s, n;
		enter(SMCG_MODE_PDOWN, 1'b1, s);
		chk("pd_no_adc", 4'h0, 4'(s));
		chk("pd_enables", 4'h0, ens());
		chk("pd_async", 4'h0, {3'h0, async_clk_en});
		any_irq = 1'b1;
		adc_done_irq = 1'b1;
		timer2_irq = 1'b1;
		repeat (4) @(negedge clk);
		{any_irq, adc_done_irq, timer2_irq} = 3'h0;
		chk("pd_stays", 4'h1, {3'h0, asleep});
		pin_change_irq = 1'b1;
		@(negedge clk);
		pin_change_irq = 1'b0;
		n = 1;
		chk("pd_osc_up", 4'h1, {3'h0, osc_en});
		while (core_clk_en !== 1'b1 && n < 40) begin
			@(negedge clk);
			n++;
		end
		// Restart must not finish before the selected count, nor much after it.
		chk("pd_delay", 4'h1, 4'(n >= int'(SMCG_DLY_CYC2) && n <= int'(SMCG_DLY_CYC2) + 4));
		chk("pd_awake", 4'hf, ens());
	endtask

	// Wakes power-down from the level source, holding the level well past the wake edge.
	task automatic level_case();
		int s;
		enter(SMCG_MODE_PDOWN, 1'b0, s);
		chk("lvl_async_off", 4'h0, {3'h0, async_clk_en});
		level_irq_zero = 1'b1;
		repeat (4) @(negedge clk);
		level_irq_zero = 1'b0;
		chk("lvl_restart", 4'h2, {2'h0, state_out});
		repeat (8) @(negedge clk);
		chk("lvl_awake", 4'hf, ens());
		chk("lvl_run", 4'h0, {2'h0, state_out});
	endtask

	task automatic misc_case();
		int s;
		enter(3'h3, 1'b1, s);
		chk("reserved_no_adc", 4'h0, 4'(s));
		chk("reserved_enables", 4'hf, ens());
		chk("reserved_asleep", 4'h0, {3'h0, asleep});
		comparator_disable = 1'b1;
		repeat (2) @(negedge clk);
		chk("cmp_off", 4'h0, {3'h0, comparator_power});
		comparator_disable = 1'b0;
		repeat (2) @(negedge clk);
		chk("cmp_on", 4'h1, {3'h0, comparator_power});
	endtask

	initial begin
		err_total = 0;
		n_checks = 0;
		rst = 1'b1;
		{sleep_exec, adc_enable, comparator_disable, any_irq, adc_done_irq} = 5'h0;
		{ext_reset, wdt_reset, bod_reset, lcd_irq, serial_start_irq} = 5'h0;
		{timer2_irq, store_ready_irq, level_irq_zero, pin_change_irq} = 4'h0;
		sleep_enable = 1'b1;
		sleep_mode_select = 3'h0;
		clock_source_fuses = 2'h2;
		repeat (8) @(negedge clk);
		rst = 1'b0;
		chk("reset_enables", 4'hf, ens());
		chk("reset_state", 4'h0, {2'h0, state_out});
		idle_case();
		noise_case();
		pdown_case();
		level_case();
		misc_case();
		report_and_stop();
	end

	initial begin
		repeat (5000) @(posedge clk);
		err_total++;
		report_and_stop();
	end
endmodule
